// File: hdl/event_timer.sv
/*
 millisecond timer: counts enabled ticks up to LIMIT, holds done as a level.
 assumes tick_i is a one-cycle enable from the main divider.
*/
`timescale 1ns/10ps
module event_timer #(
	parameter int LIMIT = 90,
	parameter int WIDTH = 12
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic clear_i,
	output logic done_o
);
	localparam logic [WIDTH-1:0] LIMIT_W = WIDTH'(LIMIT);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic next_done;

	always_comb
	begin
		next_count = count;
		if (clear_i)
			next_count = '0;
		else if (run_i && tick_i && count != LIMIT_W)
			next_count = count + 1'b1;
		next_done = (next_count == LIMIT_W);
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			count <= '0;
			done_o <= 1'b0;
		end
		else
		begin
			count <= next_count;
			done_o <= next_done;
		end
	end
endmodule // event_timer

// File: hdl/led_fault_sequencer.sv
/*
 switching control and fault sequencing for a quasi-resonant led driver controller.
 assumes all analog levels arrive as comparator bits or codes synchronous to mclk_i;
 version inputs are straps that do not change while running.
*/
`timescale 1ns/10ps
module led_fault_sequencer
	import led_seq_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES,
	parameter int AUX_LIMIT = AUX_SHORT_MS,
	parameter int WAIT_LIMIT = RECOVER_MS
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic vcc_run_i,
	input wire logic vcc_ovp_i,
	input wire logic cs_limit_i,
	input wire logic cs_over150_i,
	input wire logic cs_setpoint_i,
	input wire logic cs_pin_fault_i,
	input wire logic valley_i,
	input wire logic valley_sense_high_i,
	input wire logic high_line_i,
	input wire logic light_load_i,
	input wire logic relock_i,
	input wire logic thermal_trip_i,
	input wire logic thermal_ovp_i,
	input wire logic thermal_fold_i,
	input wire logic [7:0] thermal_scale_i,
	input wire logic dim_zero_i,
	input wire logic dim_full_i,
	input wire logic [7:0] dim_scale_i,
	input wire logic ota_sinking_i,
	input wire logic [9:0] comp_code_i,
	input wire logic version_latch_i,
	input wire logic version_low_ref_i,
	output logic gate_o,
	output logic comp_ground_o,
	output logic comp_boost_o,
	output logic [9:0] current_ref_o,
	output logic [9:0] setpoint_o,
	output logic [2:0] valley_target_o,
	output logic recovering_o,
	output logic fault_latched_o,
	output logic [2:0] fault_cause_o
);
	localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);

	seq_state_t state, next_state;
	fault_cause_t cause, next_cause;
	logic [15:0] tick_cnt, next_tick_cnt;
	logic tick, next_tick;
	logic aux_done, wait_done;
	logic [2:0] ovc_cnt, next_ovc_cnt;
	logic [2:0] valley_cnt, next_valley_cnt;
	logic [2:0] next_target;
	logic over_seen, next_over_seen;
	logic next_gate, allowed, fault_now, sink_seen, next_sink_seen;
	logic [13:0] ripple_acc, next_ripple_acc;
	logic [9:0] full_ref;
	logic [8:0] fold_factor, dim_factor;
	logic [27:0] ref_product;

	// slow time base: one enable per millisecond
	always_comb
	begin
		next_tick = (tick_cnt == TICK_LAST);
		next_tick_cnt = next_tick ? 16'h0000 : tick_cnt + 16'h0001;
	end

	// operating time only: paused across hiccup gaps, so the short still trips
	event_timer #(.LIMIT(AUX_LIMIT), .WIDTH(12)) u_aux_timer (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.tick_i(tick),
		.run_i(state == ST_RUN),
		.clear_i(valley_sense_high_i || state == ST_WAIT || state == ST_LATCH),
		.done_o(aux_done)
	);

	event_timer #(.LIMIT(WAIT_LIMIT), .WIDTH(12)) u_wait_timer (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.tick_i(tick),
		.run_i(state == ST_WAIT),
		.clear_i(state != ST_WAIT),
		.done_o(wait_done)
	);

	// switching cycle: valley counting, turn-on, turn-off, overcurrent run length
	always_comb
	begin
		allowed = (state == ST_RUN) && !cs_pin_fault_i && !dim_zero_i && !fault_now;
		next_gate = gate_o;
		next_ovc_cnt = ovc_cnt;
		next_valley_cnt = valley_cnt;
		next_over_seen = over_seen;
		if (state != ST_RUN)
			next_ovc_cnt = 3'h0;
		if (gate_o)
		begin
			next_over_seen = over_seen || cs_over150_i;
			if (cs_limit_i || cs_setpoint_i || !allowed)
			begin
				next_gate = 1'b0;
				next_valley_cnt = 3'h0;
				next_ovc_cnt = (over_seen || cs_over150_i) ? ovc_cnt + 3'h1 : 3'h0;
			end
		end
		else if (valley_i && allowed)
		begin
			if (valley_cnt + 3'h1 >= valley_target_o)
			begin
				next_gate = 1'b1;
				next_valley_cnt = 3'h0;
				next_over_seen = 1'b0;
			end
			else
				next_valley_cnt = valley_cnt + 3'h1;
		end
		else if (!allowed)
			next_valley_cnt = 3'h0;
	end

	// valley lock: only moves on a significant change of line or setpoint
	always_comb
	begin
		next_target = valley_target_o;
		if (relock_i)
		begin
			if (light_load_i && valley_target_o != VALLEY_MAX)
				next_target = valley_target_o + 3'h1;
			else if (!light_load_i)
				next_target = high_line_i ? VALLEY_HIGH_LINE : VALLEY_LOW_LINE;
		end
	end

	// sequencer: two fault states, wait and latch; the wait ignores new faults
	always_comb
	begin
		fault_now = 1'b1;
		next_cause = cause;
		if (vcc_ovp_i)
			next_cause = CAUSE_SUPPLY_OVP;
		else if (thermal_trip_i || thermal_ovp_i)
			next_cause = CAUSE_THERMAL;
		else if (aux_done)
			next_cause = CAUSE_AUX_SHORT;
		else if (ovc_cnt == OVC_CYCLES)
			next_cause = CAUSE_OVERCURRENT;
		else
			fault_now = 1'b0;
		next_state = state;
		case (state)
			ST_OFF, ST_RUN:
			begin
				if (fault_now)
					next_state = (version_latch_i && !vcc_ovp_i) ? ST_LATCH : ST_WAIT;
				else if (state == ST_OFF && vcc_run_i)
					next_state = ST_RUN;
				else if (state == ST_RUN && !vcc_run_i)
					next_state = ST_OFF;
			end
			ST_WAIT:
			begin
				next_cause = cause;
				if (wait_done)
					next_state = ST_OFF;
			end
			ST_LATCH:
				next_cause = cause;
			default:
				next_state = ST_OFF;
		endcase
	end

	// comp node: grounded only in the fault states, boost until the amplifier sinks
	// kept across an undervoltage stop, so a hiccup restart runs without the boost
	always_comb
	begin
		next_sink_seen = sink_seen || ota_sinking_i;
		if (next_state == ST_WAIT || next_state == ST_LATCH)
			next_sink_seen = 1'b0;
	end

	// ripple filter: first order average, time constant well above a half-line period
	always_comb
	begin
		next_ripple_acc = ripple_acc;
		if (state == ST_WAIT || state == ST_LATCH)
			next_ripple_acc = 14'h0000;
		else if (tick)
			next_ripple_acc = ripple_acc + {4'h0, comp_code_i}
				- {4'h0, ripple_acc[13:RIPPLE_SHIFT]};
	end

	// reference: full scale by version, scaled by foldback and dimming in product
	always_comb
	begin
		full_ref = version_low_ref_i ? REF_LOW_MV : REF_HIGH_MV;
		fold_factor = SCALE_UNITY;
		if (thermal_fold_i)
			fold_factor = ({1'b0, thermal_scale_i} < FOLD_FLOOR) ? FOLD_FLOOR
				: {1'b0, thermal_scale_i};
		dim_factor = dim_full_i ? SCALE_UNITY : {1'b0, dim_scale_i};
		ref_product = {18'h0_0000, full_ref} * {19'h0_0000, fold_factor}
			* {19'h0_0000, dim_factor};
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state <= ST_OFF;
			cause <= CAUSE_NONE;
			tick_cnt <= 16'h0000;
			tick <= 1'b0;
			ovc_cnt <= 3'h0;
			valley_cnt <= 3'h0;
			over_seen <= 1'b0;
			sink_seen <= 1'b0;
			ripple_acc <= 14'h0000;
			gate_o <= 1'b0;
			comp_ground_o <= 1'b0;
			comp_boost_o <= 1'b0;
			current_ref_o <= 10'h000;
			setpoint_o <= 10'h000;
			valley_target_o <= VALLEY_LOW_LINE;
			recovering_o <= 1'b0;
			fault_latched_o <= 1'b0;
			fault_cause_o <= CAUSE_NONE;
		end
		else
		begin
			state <= next_state;
			cause <= next_cause;
			tick_cnt <= next_tick_cnt;
			tick <= next_tick;
			ovc_cnt <= next_ovc_cnt;
			valley_cnt <= next_valley_cnt;
			over_seen <= next_over_seen;
			sink_seen <= next_sink_seen;
			ripple_acc <= next_ripple_acc;
			gate_o <= next_gate;
			comp_ground_o <= (next_state == ST_WAIT) || (next_state == ST_LATCH);
			comp_boost_o <= (next_state == ST_RUN) && !next_sink_seen;
			current_ref_o <= ref_product[25:16];
			setpoint_o <= {2'b00, next_ripple_acc[13:RIPPLE_SHIFT+SETPOINT_SHIFT]};
			valley_target_o <= next_target;
			recovering_o <= (next_state == ST_WAIT);
			fault_latched_o <= (next_state == ST_LATCH);
			fault_cause_o <= next_cause;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_peak_turnoff: assert property (gate_o && cs_limit_i |=> !gate_o)
		else $error("gate stayed on after peak limit");
	a_ovc_stop: assert property (gate_o && cs_limit_i && cs_over150_i && ovc_cnt == 3'h3
		&& state == ST_RUN |=> ##1 (recovering_o || fault_latched_o))
		else $error("fourth overcurrent cycle did not stop switching");
	a_thermal_mode: assert property (state == ST_RUN && thermal_trip_i && !vcc_ovp_i
		|=> (fault_latched_o == $past(version_latch_i)) && (recovering_o != fault_latched_o))
		else $error("thermal fault took the wrong protection mode");
	a_ovp_wait: assert property (state == ST_RUN && vcc_ovp_i |=> recovering_o && !gate_o)
		else $error("supply overvoltage did not start the wait");
	a_pin_block: assert property (cs_pin_fault_i || dim_zero_i |=> !gate_o)
		else $error("gate on with sense pin fault or dim below zero");
	a_comp_ground: assert property ($rose(recovering_o) || $rose(fault_latched_o)
		|-> comp_ground_o && !comp_boost_o)
		else $error("comp not grounded in fault state");
	a_uvlo_keep: assert property (state == ST_RUN && !vcc_run_i && !fault_now
		|=> !comp_ground_o ##1 !comp_ground_o)
		else $error("undervoltage stop grounded comp");
	a_boost_off: assert property (ota_sinking_i |=> !comp_boost_o)
		else $error("boost source on while amplifier sinks");
	a_wait_hold: assert property (recovering_o |=> recovering_o || state == ST_OFF)
		else $error("wait left other than to a fresh start");
	a_ref_full: assert property (!thermal_fold_i && dim_full_i |=> current_ref_o ==
		($past(version_low_ref_i) ? REF_LOW_MV : REF_HIGH_MV))
		else $error("reference not full scale");
	// setpoint turn-off, entry, hold and lock checks on the sequencer
	a_setpoint_end: assert property (gate_o && cs_setpoint_i |=> !gate_o)
		else $error("gate stayed on after setpoint crossing");
	a_aux_fault: assert property (aux_done && state == ST_RUN && !vcc_ovp_i
		&& !thermal_trip_i && !thermal_ovp_i
		|=> fault_cause_o == CAUSE_AUX_SHORT && (recovering_o || fault_latched_o))
		else $error("aux short did not stop switching");
	a_valley_lock: assert property (!relock_i |=> $stable(valley_target_o))
		else $error("valley target moved without a relock");
	a_latch_hold: assert property (fault_latched_o |=> fault_latched_o && !gate_o)
		else $error("latched state left or gate driven");
	a_wait_gate: assert property (recovering_o |-> !gate_o)
		else $error("gate driven during the recovery wait");
	a_cause_hold: assert property (recovering_o |=> $stable(fault_cause_o))
		else $error("fault cause changed during the wait");
	a_ovp_version: assert property (vcc_ovp_i && state != ST_WAIT && state != ST_LATCH
		|=> recovering_o && !fault_latched_o)
		else $error("supply overvoltage did not take the wait");

	c_recover: cover property ($fell(recovering_o) ##[1:20] state == ST_RUN);
	c_latch: cover property ($rose(fault_latched_o));
	c_hiccup: cover property (state == ST_RUN ##1 state == ST_OFF ##[1:20] state == ST_RUN);
	c_switch: cover property ($rose(gate_o) ##[1:50] $fell(gate_o));
endmodule // led_fault_sequencer

// File: hdl/led_seq_pkg.sv
/*
 package of constants, states and fault causes for the led driver fault sequencer.
 assumes a 40 MHz mclk_i and comparator results that are already synchronous.
*/
// Operation
// - gate drive ends in the cycle after the peak limit comparator trips.
// - four consecutive cycles above 150% of peak limit stop switching as fault.
// - thermal shutdown or thermal overvoltage latch off or wait 4 s, by version.
// - no valley pulse above 1 V within 90 ms operation gives aux short fault.
// - supply overvoltage stops switching and waits 4 s before a restart.
// - thermal foldback reduces the reference to no less than half; second level stops.
// - pulling the thermal input below its trip level shuts the device down.
// - grounded or open current sense input blocks switching while it lasts.
// - each on-time ends when sensed current exceeds control voltage over four.
// - later valleys at light load; chosen valley stays locked until a big change.
// - current reference is full scale unless foldback or dimming lowers it.
// - full scale reference is 250 mV or 200 mV, by version.
// - major fault grounds the compensation node; supply undervoltage does not.
// - extra 80 uA start-up source runs until the amplifier starts sinking.
// - after undervoltage stop, restart at start level keeping compensation voltage.
// - shorted load hiccups between supply levels until aux short trips.
// - compensation ripple is filtered digitally before forming the setpoint.
// - foldback and dimming reductions multiply rather than take the smaller.
// - gate drive is disabled while dimming input is below zero level.
package led_seq_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_HZ = 1000;
	localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
	localparam int AUX_SHORT_MS = 90;
	localparam int RECOVER_S = 4;
	localparam int RECOVER_MS = RECOVER_S * 1000;
	localparam logic [2:0] OVC_CYCLES = 3'h4;
	localparam logic [9:0] REF_HIGH_MV = 10'h0fa;
	localparam logic [9:0] REF_LOW_MV = 10'h0c8;
	localparam logic [8:0] SCALE_UNITY = 9'h100;
	localparam logic [8:0] FOLD_FLOOR = 9'h080;
	localparam int RIPPLE_SHIFT = 4;
	localparam int SETPOINT_SHIFT = 2;
	localparam logic [2:0] VALLEY_LOW_LINE = 3'h1;
	localparam logic [2:0] VALLEY_HIGH_LINE = 3'h2;
	localparam logic [2:0] VALLEY_MAX = 3'h7;
	typedef enum logic [3:0] {
		ST_OFF = 4'b0001,
		ST_RUN = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_LATCH = 4'b1000
	} seq_state_t;
	typedef enum logic [2:0] {
		CAUSE_NONE = 3'h0,
		CAUSE_OVERCURRENT = 3'h1,
		CAUSE_AUX_SHORT = 3'h2,
		CAUSE_THERMAL = 3'h3,
		CAUSE_SUPPLY_OVP = 3'h4
	} fault_cause_t;
endpackage

// File: verification/power_stage_model.sv
/*
 power stage model: switch current ramp, valley ringing and aux winding sense.
 assumes gate_i comes from the sequencer and the mode inputs from the testbench.
*/
`timescale 1ns/10ps
module power_stage_model (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic gate_i,
	input wire logic over_i,
	input wire logic short_i,
	input wire logic slow_i,
	output logic valley_o,
	output logic sense_high_o,
	output logic cs_setpoint_o,
	output logic cs_limit_o
);
	logic [3:0] cnt;
	logic [3:0] age;
	logic gate_d;
	// age restarts in the cycle the gate moves, so no stale count leaks into the next phase
	assign age = (gate_i != gate_d) ? 4'h0 : cnt;
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt <= 4'h0;
			gate_d <= 1'b0;
		end
		else
		begin
			cnt <= (gate_i != gate_d) ? 4'h1 : cnt + 4'h1;
			gate_d <= gate_i;
		end
	end
	// slow mode doubles the setpoint ramp and the ringing period; the limit trip time is unchanged
	assign cs_setpoint_o = gate_i && (slow_i ? age[3] : age[2]);
	assign cs_limit_o = gate_i && over_i && age[1];
	// a shorted winding still clocks valleys by timeout but never rises above 1 V
	assign valley_o = !gate_i && (slow_i ? &age[2:0] : &age[1:0]);
	assign sense_high_o = valley_o && !short_i;
endmodule // power_stage_model

// File: verification/testbench.sv
/*
 self-checking bench for the led fault sequencer beside a power stage model.
 assumes short parameters: 10 cycle tick, 3 tick aux limit, 4 tick recovery wait.
*/
`timescale 1ns/10ps
module testbench;
	logic mclk_i, rst_i, vcc_run_i, vcc_ovp_i, cs_limit_i, cs_over150_i, cs_setpoint_i;
	logic cs_pin_fault_i, valley_i, valley_sense_high_i, high_line_i, light_load_i, relock_i;
	logic thermal_trip_i, thermal_ovp_i, thermal_fold_i, dim_zero_i, dim_full_i;
	logic ota_sinking_i, version_latch_i, version_low_ref_i, ps_over, ps_short, ps_slow;
	logic [7:0] thermal_scale_i, dim_scale_i;
	logic [9:0] comp_code_i, current_ref_o, setpoint_o;
	logic gate_o, comp_ground_o, comp_boost_o, recovering_o, fault_latched_o;
	logic [2:0] valley_target_o, fault_cause_o;
	int bad_count;
	int checks_done;
	assign cs_over150_i = cs_limit_i;
	led_fault_sequencer #(.TICK_DIV(10), .AUX_LIMIT(3), .WAIT_LIMIT(4)) u_dut (.*);
	power_stage_model u_stage (.mclk_i(mclk_i), .rst_i(rst_i), .gate_i(gate_o),
		.over_i(ps_over), .short_i(ps_short), .slow_i(ps_slow), .valley_o(valley_i),
		.sense_high_o(valley_sense_high_i), .cs_setpoint_o(cs_setpoint_i),
		.cs_limit_o(cs_limit_i));
	initial
	begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	task step(input int n);
		repeat (n) @(posedge mclk_i);
		#2;
	endtask
	task check_code(input logic [9:0] got, input logic [9:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic probe(input int k);
		case (k)
			0: return gate_o;
			1: return comp_boost_o;
			2: return recovering_o;
			3: return fault_latched_o;
			default: return comp_ground_o;
		endcase
	endfunction
	// a limit of zero makes this a plain check of the present level
	task wait_for(input int k, input logic lvl, input int lim);
		int i;
		i = 0;
		while (probe(k) !== lvl && i < lim)
		begin
			step(1);
			i++;
		end
		check_code({9'h000, probe(k)}, {9'h000, lvl});
	endtask
	task hold_low(input int k, input int n);
		repeat (n)
		begin
			wait_for(k, 1'b0, 0);
			step(1);
		end
	endtask
	task do_reset(input logic l, input logic r);
		rst_i = 1'b1;
		version_latch_i = l;
		version_low_ref_i = r;
		{vcc_ovp_i, cs_pin_fault_i, high_line_i, light_load_i, relock_i, ota_sinking_i} = '0;
		{thermal_trip_i, thermal_ovp_i, thermal_fold_i, dim_zero_i, ps_over, ps_short} = '0;
		{vcc_run_i, dim_full_i, ps_slow} = 3'h6;
		{thermal_scale_i, dim_scale_i, comp_code_i} = {8'hff, 8'hff, 10'h200};
		step(5);
		rst_i = 1'b0;
	endtask
	task t_start;
		do_reset(1'b0, 1'b0);
		rst_i = 1'b1;
		step(1);
		check_code({7'h00, valley_target_o}, 10'h001);
		wait_for(0, 1'b0, 0);
		rst_i = 1'b0;
		wait_for(1, 1'b1, 3);
		wait_for(0, 1'b1, 30);
		check_code(current_ref_o, 10'h0fa);
		wait_for(0, 1'b0, 10);
		ota_sinking_i = 1'b1;
		wait_for(1, 1'b0, 3);
		$display("start test done");
	endtask
	task t_over;
		do_reset(1'b0, 1'b0);
		ps_over = 1'b1;
		wait_for(2, 1'b1, 120);
		check_code({7'h00, fault_cause_o}, 10'h001);
		wait_for(4, 1'b1, 0);
		ps_over = 1'b0;
		thermal_ovp_i = 1'b1;
		step(3);
		thermal_ovp_i = 1'b0;
		check_code({7'h00, fault_cause_o}, 10'h001);
		hold_low(0, 10);
		wait_for(2, 1'b0, 60);
		wait_for(4, 1'b0, 2);
		wait_for(0, 1'b1, 40);
		$display("overcurrent test done");
	endtask
	task t_latch;
		do_reset(1'b1, 1'b0);
		wait_for(0, 1'b1, 30);
		thermal_trip_i = 1'b1;
		wait_for(3, 1'b1, 3);
		check_code({7'h00, fault_cause_o}, 10'h003);
		wait_for(4, 1'b1, 0);
		thermal_trip_i = 1'b0;
		hold_low(0, 60);
		wait_for(3, 1'b1, 0);
		$display("latch test done");
	endtask
	task t_aux;
		do_reset(1'b0, 1'b0);
		ps_short = 1'b1;
		step(12);
		vcc_run_i = 1'b0;
		hold_low(2, 40);
		wait_for(4, 1'b0, 0);
		vcc_run_i = 1'b1;
		wait_for(2, 1'b1, 60);
		check_code({7'h00, fault_cause_o}, 10'h002);
		$display("aux short test done");
	endtask
	task t_ovp;
		do_reset(1'b1, 1'b0);
		wait_for(0, 1'b1, 30);
		vcc_ovp_i = 1'b1;
		wait_for(2, 1'b1, 3);
		check_code({7'h00, fault_cause_o}, 10'h004);
		wait_for(3, 1'b0, 0);
		vcc_ovp_i = 1'b0;
		wait_for(2, 1'b0, 60);
		$display("supply ovp test done");
	endtask
	task t_uv;
		do_reset(1'b0, 1'b0);
		ps_slow = 1'b1;
		wait_for(0, 1'b1, 40);
		vcc_run_i = 1'b0;
		wait_for(0, 1'b0, 3);
		hold_low(4, 5);
		vcc_run_i = 1'b1;
		wait_for(0, 1'b1, 40);
		$display("undervoltage test done");
	endtask
	task t_ref;
		do_reset(1'b0, 1'b1);
		step(2);
		check_code(current_ref_o, 10'h0c8);
		thermal_fold_i = 1'b1;
		thermal_scale_i = 8'h40;
		step(3);
		check_code(current_ref_o, 10'h064);
		{thermal_scale_i, dim_scale_i, dim_full_i} = {8'h80, 8'h80, 1'b0};
		step(3);
		check_code(current_ref_o, 10'h032);
		step(1300);
		check_code(setpoint_o, 10'h080);
		$display("reference test done");
	endtask
	task t_block;
		do_reset(1'b0, 1'b0);
		wait_for(0, 1'b1, 30);
		dim_zero_i = 1'b1;
		wait_for(0, 1'b0, 3);
		hold_low(0, 10);
		dim_zero_i = 1'b0;
		wait_for(0, 1'b1, 30);
		cs_pin_fault_i = 1'b1;
		wait_for(0, 1'b0, 3);
		hold_low(0, 10);
		cs_pin_fault_i = 1'b0;
		wait_for(0, 1'b1, 30);
		$display("block test done");
	endtask
	task t_valley;
		do_reset(1'b0, 1'b0);
		high_line_i = 1'b1;
		relock_i = 1'b1;
		step(1);
		relock_i = 1'b0;
		step(2);
		check_code({7'h00, valley_target_o}, 10'h002);
		{light_load_i, relock_i} = 2'h3;
		step(1);
		relock_i = 1'b0;
		step(2);
		check_code({7'h00, valley_target_o}, 10'h003);
		high_line_i = 1'b0;
		step(3);
		check_code({7'h00, valley_target_o}, 10'h003);
		$display("valley test done");
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		bad_count = 0;
		checks_done = 0;
		t_start();
		t_over();
		t_latch();
		t_aux();
		t_ovp();
		t_uv();
		t_ref();
		t_block();
		t_valley();
		final_report();
	end
	// whole run needs about two thousand cycles; eight thousand leaves ample margin
	initial
	begin
		#(25 * 8000);
		bad_count++;
		final_report();
	end
endmodule // testbench
